// ==== pmtp_chk.sv ====
// assertions on the wires between the two transmit ends
// assumes clk_i is the reference clock of both ends
`timescale 1ns/1ps
`default_nettype none
`include "pmtp_consts.svh"

module pmtp_chk (
    input wire logic clk_i,                       // reference clock
    input wire logic arst_n_i,                    // async reset, low
    input wire pmtp_pkg::pmtp_mode_t mode_i,      // interface mode
    input wire pmtp_pkg::pmtp_speed_t speed_i,    // link speed
    input wire logic tx_clk_phy,                  // phy clock value
    input wire logic tx_clk_phy_oe,               // phy drives clock
    input wire logic tx_clk_mac,                  // mac clock value
    input wire logic tx_clk_mac_oe,               // mac drives clock
    input wire logic tx_clk,                      // resolved clock pin
    input wire logic ref_clk,                     // rmii reference
    input wire logic tx_en,                       // enable or control
    input wire logic [`PMTP_DATA_W-1:0] tx_data   // data lines
);
    import pmtp_pkg::*;

    logic prev_q;
    logic seen_q;
    logic [5:0] run_q;
    logic [5:0] half;

    // first toggle after reset skipped: divider phase there is free
    assign half = (speed_i == PMTP_100M) ? 6'h02 : 6'h14;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_q <= 1'b0;
            seen_q <= 1'b0;
            run_q <= 6'h00;
        end else begin
            prev_q <= tx_clk;
            if (tx_clk != prev_q) begin
                seen_q <= 1'b1;
                run_q <= 6'h00;
            end else begin
                run_q <= run_q + 6'h01;
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_clk_half_period:
    assert property ((mode_i != PMTP_RMII && seen_q && tx_clk != prev_q)
        |-> run_q == half - 6'h01) else $error("clock half period wrong");
    a_reset_pin_low:
    assert property ($rose(arst_n_i) |-> tx_clk_phy_oe && !tx_clk_phy
        && !tx_clk) else $error("clock pin not low in reset");
    a_rgmii_pin_input:
    assert property (($past(arst_n_i, 2) && mode_i == PMTP_RGMII)
        |-> !tx_clk_phy_oe && tx_clk_mac_oe) else $error("rgmii clock owner");
    a_mii_phy_source:
    assert property (($past(arst_n_i) && mode_i == PMTP_MII)
        |-> tx_clk_phy_oe && !tx_clk_mac_oe) else $error("mii clock owner");
    a_rmii_clock_quiet:
    assert property (($past(arst_n_i) && mode_i == PMTP_RMII)
        |-> !tx_clk_phy_oe && !tx_clk_mac_oe && !tx_clk)
        else $error("clock driven in rmii");
    a_mii_data_hold:
    assert property (($rose(tx_clk) && mode_i == PMTP_MII)
        |=> ($stable(tx_en) && $stable(tx_data)) [*2])
        else $error("mii lines moved at clock rise");
    a_rmii_data_hold:
    assert property (($rose(ref_clk) && mode_i == PMTP_RMII)
        |=> $stable(tx_en) && $stable(tx_data))
        else $error("rmii lines moved at reference rise");
    a_rmii_two_lines:
    assert property (mode_i == PMTP_RMII |-> tx_data[3:2] == 2'h0)
        else $error("rmii upper data lines active");
    a_rgmii_data_launch:
    assert property ((mode_i == PMTP_RGMII && $changed(tx_data))
        |-> $fell(tx_clk_mac)) else $error("rgmii data off clock fall");
    a_rgmii_ctrl_edge:
    assert property ((mode_i == PMTP_RGMII && $changed(tx_en))
        |-> $changed(tx_clk_mac)) else $error("rgmii control off clock edge");
endmodule

`default_nettype wire

// ==== pmtp_consts.svh ====
// constants for the mac-facing transmit port: clock rates and widths
// assumes the system clock below is the reference clock of both ends
`ifndef PMTP_CONSTS_SVH
`define PMTP_CONSTS_SVH

// system clock, 100 MHz
`define PMTP_CLK_HZ 32'h05F5_E100
// transmit clock at 100 Mbps, 25 MHz
`define PMTP_FAST_HZ 32'h017D_7840
// transmit clock at 10 Mbps, 2.5 MHz
`define PMTP_SLOW_HZ 32'h0026_25A0
// half periods of the transmit clock in system clock cycles
`define PMTP_HALF_FAST (`PMTP_CLK_HZ / (32'h0000_0002 * `PMTP_FAST_HZ))
`define PMTP_HALF_SLOW (`PMTP_CLK_HZ / (32'h0000_0002 * `PMTP_SLOW_HZ))
`define PMTP_DIV_W 5
`define PMTP_DATA_W 4
`define PMTP_BYTE_W 8
`define PMTP_SYNC_W 3
// last chunk index of a byte: two nibbles or four bit pairs
`define PMTP_LAST_NIB 2'h1
`define PMTP_LAST_DIB 2'h3

`endif

// ==== pmtp_if.sv ====
// wires between the phy transmit end and the mac transmit end
// assumes the bench drives ref_clk; tx_clk is resolved from both enables
`timescale 1ns/1ps
`default_nettype none
`include "pmtp_consts.svh"

interface pmtp_if;
    logic tx_clk_phy;
    logic tx_clk_phy_oe;
    logic tx_clk_mac;
    logic tx_clk_mac_oe;
    logic tx_clk;
    logic ref_clk;
    logic tx_en;
    logic transmit_error_indication;
    logic [`PMTP_DATA_W-1:0] tx_data;

    // pull-down when nobody drives; phy wins if both drive
    assign tx_clk = tx_clk_phy_oe ? tx_clk_phy :
                    (tx_clk_mac_oe ? tx_clk_mac : 1'b0);

    modport phy (
        input tx_clk,
        input ref_clk,
        input tx_en,
        input transmit_error_indication,
        input tx_data,
        output tx_clk_phy,
        output tx_clk_phy_oe
    );

    modport mac (
        input tx_clk,
        input ref_clk,
        output tx_clk_mac,
        output tx_clk_mac_oe,
        output tx_en,
        output transmit_error_indication,
        output tx_data
    );
endinterface

`default_nettype wire

// ==== pmtp_mac_end.sv ====
// mac end of the transmit port: splits user bytes onto the pins
// assumes mode and speed are static and come from the clk_i domain;
// the phy end must be out of reset before rgmii mode drives the clock
//
// Notes on behaviour
// - mii: phy outputs 25 or 2.5 MHz
// - mii clock phase fixed to reference clock
// - rgmii: mac sources 25 or 2.5 MHz
// - clock pin driven low in reset
// - enable active high, sampled rising edge
// - mii nibble synchronous to phy clock
// - rmii bit pairs on reference clock
// - rgmii nibble on mac clock rising
`timescale 1ns/1ps
`default_nettype none

module pmtp_mac_end (
    input wire logic clk_i,                       // system clock
    input wire logic arst_n_i,                    // async reset, low
    input wire logic ce_i,                        // clock enable
    input wire pmtp_pkg::pmtp_mode_t mode_i,      // interface mode
    input wire pmtp_pkg::pmtp_speed_t speed_i,    // link speed
    pmtp_if.mac link,                             // phy-facing pins
    input wire logic tx_valid_i,                  // byte offered
    input wire logic [7:0] tx_data_i,             // byte to send
    input wire logic tx_last_i,                   // last byte of frame
    input wire logic tx_err_i,                    // mark byte errored
    output logic tx_ready_o,                      // byte taken
    output logic tx_busy_o,                       // enable on the pins outside rgmii
    output logic tx_underrun_o                    // frame cut short
);
    import pmtp_pkg::*;

    pmtp_mac_st_t q;
    pmtp_mac_st_t d;
    pmtp_div_t half;
    logic wrap;
    logic rg_rise;
    logic rg_fall;
    logic view;
    logic rise;
    logic beat;
    logic rgmii;
    pmtp_nib_t chunk;

    // a new byte only when the holding register is empty and no gap
    assign tx_ready_o = ~q.full && (q.state != PMTP_GAP);

    always_comb begin
        d = q;
        d.underrun = 1'b0;
        rgmii = (mode_i == PMTP_RGMII);
        half = pmtp_half(speed_i);

        // own clock divider, only driven out in rgmii
        wrap = (q.cnt >= half - pmtp_div_t'(1));
        rg_rise = wrap & ~q.clk_gen;
        rg_fall = wrap & q.clk_gen;
        if (wrap) begin
            d.cnt = '0;
            d.clk_gen = ~q.clk_gen;
        end else begin
            d.cnt = q.cnt + pmtp_div_t'(1);
        end
        d.clk_oe = rgmii;

        // rmii follows the shared reference clock, mii the phy clock
        view = (mode_i == PMTP_RMII) ? link.ref_clk : link.tx_clk;
        d.ck = {q.ck[1:0], view};
        rise = q.ck[1] & ~q.ck[2];

        // rgmii updates on its own falling edge so the pins are steady
        // a half period before the phy samples on the rising edge
        if (rgmii) begin
            beat = rg_fall;
        end else begin
            beat = rise;
        end

        // pick the chunk of the held byte, low part first
        if (mode_i == PMTP_RMII) begin
            chunk = {2'h0, q.bytev[{q.pos, 1'b0} +: 2]};
        end else if (q.pos[0]) begin
            chunk = q.bytev[7:4];
        end else begin
            chunk = q.bytev[3:0];
        end

        if (tx_valid_i && tx_ready_o) begin
            d.full = 1'b1;
            d.bytev = tx_data_i;
            d.last = tx_last_i;
            d.uerr = tx_err_i;
        end

        if (beat) begin
            case (q.state)
                PMTP_IDLE, PMTP_SEND: begin
                    if (q.full) begin
                        d.en = 1'b1;
                        d.dat = chunk;
                        d.beat_err = q.uerr;
                        d.state = PMTP_SEND;
                        if (q.pos == pmtp_last_pos(mode_i)) begin
                            d.full = 1'b0;
                            d.pos = 2'h0;
                            if (q.last) begin
                                d.state = PMTP_GAP;
                            end
                        end else begin
                            d.pos = q.pos + 2'h1;
                        end
                    end else begin
                        d.en = 1'b0;
                        d.dat = '0;
                        d.beat_err = 1'b0;
                        d.underrun = (q.state == PMTP_SEND);
                        d.state = PMTP_IDLE;
                    end
                end
                PMTP_GAP: begin
                    // one idle beat keeps back-to-back frames apart
                    d.en = 1'b0;
                    d.dat = '0;
                    d.beat_err = 1'b0;
                    d.state = PMTP_IDLE;
                end
                default: begin
                    d.state = PMTP_IDLE;
                end
            endcase
            // mii has its own error line; other modes leave it low
            if (mode_i == PMTP_MII) begin
                d.er_pin = d.beat_err & d.en;
            end else begin
                d.er_pin = 1'b0;
            end
            d.ctrl = d.en;
        end

        // rgmii: error rides the control line from rise to fall
        if (rgmii && rg_rise) begin
            d.ctrl = q.en & q.beat_err;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.state <= PMTP_IDLE;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign link.tx_clk_mac = q.clk_gen;
    assign link.tx_clk_mac_oe = q.clk_oe;
    assign link.tx_en = q.ctrl;
    assign link.transmit_error_indication = q.er_pin;
    assign link.tx_data = q.dat;
    assign tx_busy_o = q.en;
    assign tx_underrun_o = q.underrun;

endmodule

`default_nettype wire

// ==== pmtp_phy_end.sv ====
// phy end of the transmit port: makes the mii clock, collects bytes
// assumes mode and speed are static and come from the clk_i domain
`timescale 1ns/1ps
`default_nettype none

module pmtp_phy_end (
    input wire logic clk_i,                       // reference clock
    input wire logic arst_n_i,                    // async reset, low
    input wire logic ce_i,                        // clock enable
    input wire pmtp_pkg::pmtp_mode_t mode_i,      // interface mode
    input wire pmtp_pkg::pmtp_speed_t speed_i,    // link speed
    pmtp_if.phy link,                             // mac-facing pins
    output logic rx_valid_o,                      // byte strobe
    output logic [7:0] rx_data_o,                 // collected byte
    output logic rx_err_o,                        // error seen in frame
    output logic rx_frame_o                       // frame in progress
);
    import pmtp_pkg::*;

    pmtp_phy_st_t q;
    pmtp_phy_st_t d;
    pmtp_div_t half;
    logic wrap;
    logic view;
    logic rise;
    logic fall;
    logic [1:0] pos_now;
    logic err_now;
    pmtp_nib_t nib;

    always_comb begin
        d = q;
        d.valid = 1'b0;
        half = pmtp_half(speed_i);
        // divider runs from reset on, so the phase to clk_i never drifts
        wrap = (q.cnt >= half - pmtp_div_t'(1));
        if (wrap) begin
            d.cnt = '0;
            d.clk_gen = ~q.clk_gen;
        end else begin
            d.cnt = q.cnt + pmtp_div_t'(1);
        end
        // drive only in mii; released to input after reset otherwise
        d.clk_oe = (mode_i == PMTP_MII);
        // rmii samples on the shared reference clock
        view = (mode_i == PMTP_RMII) ? link.ref_clk : link.tx_clk;
        d.ck = {q.ck[1:0], view};
        d.en = {q.en[1:0], link.tx_en};
        d.er = {q.er[1:0], link.transmit_error_indication};
        d.dat = {q.dat[1:0], link.tx_data};
        rise = q.ck[1] & ~q.ck[2];
        fall = ~q.ck[1] & q.ck[2];
        // oldest stage: the value held just before the clock edge
        nib = q.dat[2];
        pos_now = q.frame ? q.pos : 2'h0;
        err_now = q.frame ? q.err : 1'b0;
        if (rise) begin
            if (q.en[2]) begin
                d.frame = 1'b1;
                if (mode_i == PMTP_RMII) begin
                    d.shift = {nib[1:0], q.shift[7:2]};
                    d.err = err_now;
                end else begin
                    d.shift = {nib, q.shift[7:4]};
                    d.err = err_now;
                    if (mode_i == PMTP_MII) begin
                        d.err = err_now | q.er[2];
                    end
                end
                if (pos_now == pmtp_last_pos(mode_i)) begin
                    d.valid = 1'b1;
                    d.data = d.shift;
                    d.pos = 2'h0;
                end else begin
                    d.pos = pos_now + 2'h1;
                end
            end else begin
                // data lines ignored; a partial byte is dropped
                d.frame = 1'b0;
                d.pos = 2'h0;
            end
        end
        // rgmii control line carries the error between rise and fall
        if (fall && mode_i == PMTP_RGMII && q.frame && q.en[2]) begin
            d.err = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.clk_oe <= 1'b1;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // clk_gen resets low, so the pin is driven low during reset
    assign link.tx_clk_phy = q.clk_gen;
    assign link.tx_clk_phy_oe = q.clk_oe;
    assign rx_valid_o = q.valid;
    assign rx_data_o = q.data;
    assign rx_err_o = q.err;
    assign rx_frame_o = q.frame;

endmodule

`default_nettype wire

// ==== pmtp_pkg.sv ====
// types and shared decoding of the mac-facing transmit port
// assumes pmtp_consts.svh is on the include path
`include "pmtp_consts.svh"

package pmtp_pkg;

    typedef enum logic [1:0] {PMTP_MII, PMTP_RMII, PMTP_RGMII} pmtp_mode_t;
    typedef enum logic {PMTP_10M, PMTP_100M} pmtp_speed_t;
    typedef enum logic [1:0] {PMTP_IDLE, PMTP_SEND, PMTP_GAP} pmtp_tx_st_t;
    typedef logic [`PMTP_DIV_W-1:0] pmtp_div_t;
    typedef logic [`PMTP_DATA_W-1:0] pmtp_nib_t;
    typedef logic [`PMTP_BYTE_W-1:0] pmtp_byte_t;

    typedef struct packed {
        pmtp_div_t cnt;
        logic clk_gen;
        logic clk_oe;
        logic [`PMTP_SYNC_W-1:0] ck;
        logic [`PMTP_SYNC_W-1:0] en;
        logic [`PMTP_SYNC_W-1:0] er;
        logic [`PMTP_SYNC_W-1:0][`PMTP_DATA_W-1:0] dat;
        logic frame;
        logic err;
        logic [1:0] pos;
        pmtp_byte_t shift;
        logic valid;
        pmtp_byte_t data;
    } pmtp_phy_st_t;

    typedef struct packed {
        pmtp_div_t cnt;
        logic clk_gen;
        logic clk_oe;
        logic [`PMTP_SYNC_W-1:0] ck;
        pmtp_tx_st_t state;
        logic full;
        pmtp_byte_t bytev;
        logic last;
        logic uerr;
        logic [1:0] pos;
        logic en;
        logic beat_err;
        logic er_pin;
        logic ctrl;
        pmtp_nib_t dat;
        logic underrun;
    } pmtp_mac_st_t;

    // half period of the transmit clock for a speed
    function automatic pmtp_div_t pmtp_half(input pmtp_speed_t spd);
        pmtp_div_t h;
        if (spd == PMTP_100M) begin
            h = pmtp_div_t'(`PMTP_HALF_FAST);
        end else begin
            h = pmtp_div_t'(`PMTP_HALF_SLOW);
        end
        return h;
    endfunction

    // index of the chunk that completes a byte
    function automatic logic [1:0] pmtp_last_pos(input pmtp_mode_t mode);
        logic [1:0] p;
        if (mode == PMTP_RMII) begin
            p = `PMTP_LAST_DIB;
        end else begin
            p = `PMTP_LAST_NIB;
        end
        return p;
    endfunction

endpackage

// ==== pmtp_tb.sv ====
// bench: both ends joined by the link, random frames in every mode
// assumes design files and pmtp_chk.sv are compiled before it
`timescale 1ns/1ps
`default_nettype none

module pmtp_tb;
    import pmtp_pkg::*;

    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    pmtp_mode_t mode = PMTP_MII;
    pmtp_speed_t speed = PMTP_100M;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_last = 1'b0;
    logic tx_err = 1'b0;
    logic tx_ready, tx_busy, tx_under, rx_valid, rx_err, rx_frame;
    logic b_valid, b_frame;
    logic [7:0] rx_data;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] exp_q[$];
    pmtp_mode_t modes [5] = '{PMTP_MII, PMTP_MII, PMTP_RMII, PMTP_RGMII,
                              PMTP_RGMII};
    pmtp_speed_t speeds [5] = '{PMTP_100M, PMTP_10M, PMTP_100M, PMTP_100M,
                                PMTP_10M};

    pmtp_if link ();
    pmtp_if bad ();

    // second phy sees random data with enable held low
    assign bad.ref_clk = link.ref_clk;
    assign bad.tx_clk_mac = 1'b0;
    assign bad.tx_clk_mac_oe = 1'b0;
    assign bad.tx_en = 1'b0;

    pmtp_phy_end pmtp_phy_end_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .ce_i(1'b1), .mode_i(mode), .speed_i(speed), .link(link.phy),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_err_o(rx_err),
        .rx_frame_o(rx_frame));
    pmtp_mac_end pmtp_mac_end_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .ce_i(1'b1), .mode_i(mode), .speed_i(speed), .link(link.mac),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
        .tx_err_i(tx_err), .tx_ready_o(tx_ready), .tx_busy_o(tx_busy),
        .tx_underrun_o(tx_under));
    pmtp_phy_end pmtp_phy_end_b_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .ce_i(1'b1), .mode_i(mode), .speed_i(speed), .link(bad.phy),
        .rx_valid_o(b_valid), .rx_data_o(), .rx_err_o(),
        .rx_frame_o(b_frame));
    pmtp_chk pmtp_chk_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_i(mode),
        .speed_i(speed), .tx_clk_phy(link.tx_clk_phy),
        .tx_clk_phy_oe(link.tx_clk_phy_oe), .tx_clk_mac(link.tx_clk_mac),
        .tx_clk_mac_oe(link.tx_clk_mac_oe), .tx_clk(link.tx_clk),
        .ref_clk(link.ref_clk), .tx_en(link.tx_en), .tx_data(link.tx_data));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        link.ref_clk = 1'b0;
        #3;
        forever #80 link.ref_clk = ~link.ref_clk;
    end

    task automatic check_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", what, e, g);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] e,
                              input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            print_verdict();
        end
    end

    always @(negedge clk_i) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_bit("stray byte", 1'b0, rx_valid);
            end else begin
                check_byte("rx byte", exp_q.pop_front(), rx_data);
            end
        end
        if (tx_under !== 1'b0) check_bit("underrun", 1'b0, tx_under);
        // outside rgmii the enable pin is the busy level itself
        if (arst_n_i && mode != PMTP_RGMII && tx_busy !== link.tx_en) begin
            check_bit("busy", link.tx_en, tx_busy);
        end
        if (b_frame !== 1'b0) check_bit("idle frame", 1'b0, b_frame);
        if (b_valid !== 1'b0) check_bit("idle byte", 1'b0, b_valid);
        bad.tx_data <= 4'($urandom);
        bad.transmit_error_indication <= 1'($urandom);
    end

    task automatic do_reset(input pmtp_mode_t m, input pmtp_speed_t s);
        @(negedge clk_i);
        arst_n_i = 1'b0;
        mode = m;
        speed = s;
        repeat (12) @(negedge clk_i);
        check_bit("clock pin in reset", 1'b0, link.tx_clk);
        check_bit("clock drive in reset", 1'b1, link.tx_clk_phy_oe);
        arst_n_i = 1'b1;
    endtask

    task automatic check_period(input logic [7:0] e);
        logic p;
        int n;
        int t;
        int r;
        n = 0;
        t = 0;
        r = 0;
        p = link.tx_clk;
        while (n < 2 && t < 200) begin
            @(negedge clk_i);
            t++;
            if (link.tx_clk === 1'b1 && p === 1'b0) begin
                n++;
                r = t - r;
            end
            p = link.tx_clk;
        end
        check_byte("clock period", e, 8'(r));
    endtask

    task automatic send_frame(input int len, input int bad_at);
        int i;
        int t;
        for (i = 0; i < len; i++) begin
            t = 0;
            while (tx_ready !== 1'b1 && t < 2000) begin
                @(negedge clk_i);
                t++;
            end
            tx_valid = 1'b1;
            tx_data = 8'($urandom);
            tx_last = (i == len - 1);
            tx_err = (i == bad_at);
            exp_q.push_back(tx_data);
            @(negedge clk_i);
        end
        tx_valid = 1'b0;
    endtask

    task automatic finish_frame(input logic e);
        int t;
        t = 0;
        while ((exp_q.size() != 0 || rx_frame !== 1'b0) && t < 3000) begin
            @(negedge clk_i);
            t++;
        end
        check_bit("all bytes out", 1'b1, exp_q.size() == 0);
        check_bit("frame error", e, rx_err);
    endtask

    initial begin
        void'($urandom(41));
        for (int k = 0; k < 5; k++) begin
            do_reset(modes[k], speeds[k]);
            // cycles of 100 MHz in one period of 25 or 2.5 MHz
            if (modes[k] != PMTP_RMII) begin
                check_period(speeds[k] == PMTP_100M ? 8'h04 : 8'h28);
            end
            send_frame(3 + $urandom % 4, -1);
            finish_frame(1'b0);
            send_frame(2, -1);
            send_frame(4, $urandom % 4);
            finish_frame(modes[k] != PMTP_RMII);
            $display("test %0d done, mode %0d", k, modes[k]);
        end
        print_verdict();
    end
endmodule

`default_nettype wire
